//--- hw/scan_data_regs.sv
// Operation
// (R01) bypass is exactly one shift stage between serial in and serial out
// (R02) bypass enters the chain for bypass, clamp and high-z instructions
// (R03) id register: 32-stage shift path plus separate 32-bit parallel latch
// (R04) id register enters the chain when idcode is current
// (R05) id register also selected while in test-logic-reset
// (R06) instruction is three bits; bypass code 111, idcode code 001
// (R07) id loaded on first scan clock rise in capture-dr, shifted in shift-dr
// (R08) id code: bit0 one, then 11-bit maker, 16-bit part, 4-bit version
// (R09) bypass stage captures zero during capture-dr
`timescale 1ns/1ps
module scan_data_regs #(
   parameter logic [10:0] MFR_ID  = scan_pkg::ID_MFR_DEFAULT,
   parameter logic [15:0] PART_ID = scan_pkg::ID_PART_DEFAULT,
   parameter logic [3:0]  VER_ID  = scan_pkg::ID_VER_DEFAULT
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_b,
   input  wire logic                 scan_clock,
   input  wire logic                 scan_serial_in,
   input  wire logic [2:0]           instruction,
   input  wire scan_pkg::tap_state_t tap_state,
   output logic                      scan_serial_out,
   output logic                      scan_serial_out_oe_b,
   output logic                      chain_active,
   output logic [31:0]               id_parallel
);

   // reset release through two flops
   // assert at once, release in step so no flop leaves reset alone
   logic       rst_meta_q;
   logic       rst_sync_q;

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // pin synchronisers, first stage read only by second
   logic [1:0] clk_sync_q;
   logic [1:0] din_sync_q;
   logic       clk_last_q;

   always_ff @(posedge ref_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         clk_sync_q <= 2'b00;
         din_sync_q <= 2'b00;
         clk_last_q <= 1'b0;
      end
      else
      begin
         clk_sync_q <= {clk_sync_q[0], scan_clock};
         din_sync_q <= {din_sync_q[0], scan_serial_in};
         clk_last_q <= clk_sync_q[1];
      end
   end

   logic scan_rise;
   logic scan_fall;
   logic din_s;

   // serial in is sampled with the same latency as the clock edge
   assign scan_rise = clk_sync_q[1] & ~clk_last_q;
   assign scan_fall = ~clk_sync_q[1] & clk_last_q;
   assign din_s     = din_sync_q[1];

   // instruction decode
   logic op_bypass;
   logic op_clamp;
   logic op_highz;
   logic op_idcode;
   logic sel_bypass;
   logic sel_id;

   // (R06) fixed opcodes
   assign op_bypass = (instruction == scan_pkg::OP_BYPASS);
   assign op_clamp  = (instruction == scan_pkg::OP_CLAMP);
   assign op_highz  = (instruction == scan_pkg::OP_HIGHZ);
   assign op_idcode = (instruction == scan_pkg::OP_IDCODE);

   // (R05) reset state forces id
   assign sel_id = op_idcode | tap_state.test_logic_reset;
   // (R02) three bypass users
   assign sel_bypass = ~sel_id & (op_bypass | op_clamp | op_highz);

   scan_pkg::chain_sel_t chain_sel;

   assign chain_sel = sel_id     ? scan_pkg::SEL_ID :
                      sel_bypass ? scan_pkg::SEL_BYPASS : scan_pkg::SEL_NONE;

   // one-hot select decode
   logic is_id;
   logic is_byp;
   logic is_none;

   assign is_id   = (chain_sel == scan_pkg::SEL_ID);
   assign is_byp  = (chain_sel == scan_pkg::SEL_BYPASS);
   assign is_none = (chain_sel == scan_pkg::SEL_NONE);

   // a set bit0 tells the host an id follows, not a bypass zero
   // (R08) identification code assembly
   logic [31:0] id_code;

   assign id_code[scan_pkg::ID_MARK_POS] = scan_pkg::ID_MARK_VALUE;
   assign id_code[scan_pkg::ID_MFR_LSB +: scan_pkg::ID_MFR_WIDTH]   = MFR_ID;
   assign id_code[scan_pkg::ID_PART_LSB +: scan_pkg::ID_PART_WIDTH] = PART_ID;
   assign id_code[scan_pkg::ID_VER_LSB +: scan_pkg::ID_VER_WIDTH]   = VER_ID;

   // per-register capture and shift strobes on scan clock rise
   logic cap_id;
   logic cap_byp;
   logic sh_id;
   logic sh_byp;

   // (R07) load on capture-dr rise
   assign cap_id  = scan_rise & tap_state.capture_dr & is_id;
   // (R09) bypass captures zero
   assign cap_byp = scan_rise & tap_state.capture_dr & is_byp;
   // (R07) shift in shift-dr
   assign sh_id   = scan_rise & tap_state.shift_dr & is_id;
   assign sh_byp  = scan_rise & tap_state.shift_dr & is_byp;

   logic [scan_pkg::BYPASS_WIDTH-1:0] byp_q;
   logic [scan_pkg::ID_WIDTH-1:0]     id_shift_q;

   // (R01) single bypass stage
   shift_stage #(
      .WIDTH       (scan_pkg::BYPASS_WIDTH)
   ) u_bypass (
      .clk         (ref_clk),
      .rst_b       (rst_sync_q),
      .capture_en  (cap_byp),
      .capture_val (scan_pkg::BYPASS_CAPTURE),
      .shift_en    (sh_byp),
      .serial_in   (din_s),
      .q           (byp_q)
   );

   // (R03) 32-stage id shift path
   shift_stage #(
      .WIDTH       (scan_pkg::ID_WIDTH)
   ) u_ident (
      .clk         (ref_clk),
      .rst_b       (rst_sync_q),
      .capture_en  (cap_id),
      .capture_val (id_code),
      .shift_en    (sh_id),
      .serial_in   (din_s),
      .q           (id_shift_q)
   );

   // latch keeps the parallel word still while the shift path ripples
   // (R03) parallel latch on update-dr falling edge, forced in reset state
   logic [31:0] id_latch_q;
   logic [31:0] id_latch_d;
   logic        upd_id;

   assign upd_id     = scan_fall & tap_state.update_dr & is_id;
   assign id_latch_d = tap_state.test_logic_reset ? id_code :
                       (upd_id ? id_shift_q : id_latch_q);

   always_ff @(posedge ref_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         id_latch_q <= scan_pkg::ID_LATCH_RESET;
      else
         id_latch_q <= id_latch_d;
   end

   assign id_parallel = id_latch_q;

   // serial out retimed on falling scan edge so the far end samples a settled bit
   logic chain_bit;
   logic active_now;
   logic sout_q;
   logic sout_d;
   logic oe_b_q;
   logic oe_b_d;

   logic drive_state;

   // (R01) bypass sits directly between in and out
   assign chain_bit   = is_id ? id_shift_q[0] : byp_q[0];
   // first bit must stand at the first shift rise, so capture-dr drives too
   // tms is unseen here: an exit straight from capture drives half a clock
   assign drive_state = tap_state.capture_dr | tap_state.shift_dr;
   assign active_now  = drive_state & ~is_none;
   assign sout_d      = scan_fall ? chain_bit : sout_q;
   // pin released when no chain of ours is capturing or shifting
   assign oe_b_d      = scan_fall ? ~active_now : (oe_b_q | ~active_now);

   always_ff @(posedge ref_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         sout_q <= scan_pkg::SERIAL_OUT_RESET;
      else
         sout_q <= sout_d;
   end

   always_ff @(posedge ref_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         oe_b_q <= 1'b1;
      else
         oe_b_q <= oe_b_d;
   end

   assign scan_serial_out      = sout_q;
   assign scan_serial_out_oe_b = oe_b_q;
   assign chain_active         = ~is_none;

endmodule

//--- hw/scan_pkg.sv
package scan_pkg;

   // instruction register
   localparam int unsigned IR_WIDTH        = 3;
   localparam logic [2:0]  OP_EXTEST       = 3'h0;
   localparam logic [2:0]  OP_IDCODE       = 3'h1;
   localparam logic [2:0]  OP_SAMPLE       = 3'h2;
   localparam logic [2:0]  OP_CLAMP        = 3'h3;
   localparam logic [2:0]  OP_HIGHZ        = 3'h4;
   localparam logic [2:0]  OP_BYPASS       = 3'h7;

   // data register widths
   localparam int unsigned BYPASS_WIDTH    = 1;
   localparam int unsigned ID_WIDTH        = 32;

   // identification code layout
   localparam int unsigned ID_MARK_POS     = 0;
   localparam int unsigned ID_MFR_LSB      = 1;
   localparam int unsigned ID_MFR_WIDTH    = 11;
   localparam int unsigned ID_PART_LSB     = 12;
   localparam int unsigned ID_PART_WIDTH   = 16;
   localparam int unsigned ID_VER_LSB      = 28;
   localparam int unsigned ID_VER_WIDTH    = 4;
   localparam logic        ID_MARK_VALUE   = 1'b1;

   // identity values, arbitrary
   localparam logic [10:0] ID_MFR_DEFAULT  = 11'h02a;
   localparam logic [15:0] ID_PART_DEFAULT = 16'h1234;
   localparam logic [3:0]  ID_VER_DEFAULT  = 4'h1;

   // capture value of the bypass stage
   localparam logic        BYPASS_CAPTURE  = 1'b0;

   // reset values
   localparam logic [31:0] ID_LATCH_RESET  = 32'h0000_0000;
   localparam logic        SERIAL_OUT_RESET = 1'b0;

   // synchroniser depth
   localparam int unsigned SYNC_STAGES     = 2;

   // tap state indications from the controller, same clock domain
   typedef struct packed {
      logic test_logic_reset;
      logic capture_dr;
      logic shift_dr;
      logic update_dr;
   } tap_state_t;

   // selected data register
   typedef enum logic [2:0] {
      SEL_NONE   = 3'b001,
      SEL_BYPASS = 3'b010,
      SEL_ID     = 3'b100
   } chain_sel_t;

endpackage

//--- hw/shift_stage.sv
`timescale 1ns/1ps
module shift_stage #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             capture_en,
   input  wire logic [WIDTH-1:0] capture_val,
   input  wire logic             shift_en,
   input  wire logic             serial_in,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] q_d;
   logic [WIDTH-1:0] shifted;

   // lsb leaves first, new bit enters at the top
   if (WIDTH == 1)
   begin : g_one
      assign shifted = serial_in;
   end
   else
   begin : g_many
      assign shifted = {serial_in, q[WIDTH-1:1]};
   end

   // capture wins; otherwise hold when not shifting
   assign q_d = capture_en ? capture_val : (shift_en ? shifted : q);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= q_d;
   end

endmodule

//--- tb/scan_data_regs_checker.sv
`timescale 1ns/1ps
module scan_data_regs_checker (
   input wire logic                 ref_clk,
   input wire logic                 rst_b,
   input wire logic                 scan_clock,
   input wire logic [2:0]           instruction,
   input wire scan_pkg::tap_state_t tap_state,
   input wire logic                 scan_serial_out,
   input wire logic                 scan_serial_out_oe_b,
   input wire logic                 chain_active,
   input wire logic [31:0]          id_parallel
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire        tlr  = tap_state.test_logic_reset;
   wire        byp  = instruction inside {3'h7, 3'h3, 3'h4};
   wire        idc  = instruction == 3'h1;
   logic       clk_seen;
   always_ff @(posedge ref_clk)
      clk_seen <= scan_clock;
   wire        cap  = scan_clock && !clk_seen && tap_state.capture_dr && !tlr;
   wire        drv  = (tap_state.capture_dr || tap_state.shift_dr) && chain_active;
   wire [31:0] code = {scan_pkg::ID_VER_DEFAULT, scan_pkg::ID_PART_DEFAULT,
                       scan_pkg::ID_MFR_DEFAULT, 1'b1};
   byp_sel_a: assert property (byp |-> chain_active)
      else $error("bypass code left chain unselected");
   id_sel_a: assert property (idc |-> chain_active)
      else $error("id code left chain unselected");
   unsel_a: assert property (!tlr && !byp && !idc |-> !chain_active)
      else $error("chain selected by foreign code");
   tlr_code_a: assert property (tlr [*3] |=> id_parallel == code)
      else $error("id not forced in reset state");
   oe_idle_a: assert property (!drv |=> scan_serial_out_oe_b)
      else $error("serial out driven outside shift");
   par_hold_a: assert property ($changed(id_parallel) |-> $past(tap_state.update_dr) || $past(tlr))
      else $error("parallel id moved without update");
   byp_cap_a: assert property (cap && byp |-> ##8 scan_serial_out == 1'b0)
      else $error("bypass capture not zero");
   id_cap_a: assert property (cap && idc |-> ##8 scan_serial_out == 1'b1)
      else $error("id bit0 not one after capture");
   cover property (tap_state.update_dr && idc);
   cover property (byp && tap_state.shift_dr);
   cover property (tlr && !scan_clock);
endmodule
bind scan_data_regs scan_data_regs_checker chk (
   .ref_clk(ref_clk), .rst_b(rst_b), .scan_clock(scan_clock), .instruction(instruction),
   .tap_state(tap_state), .scan_serial_out(scan_serial_out),
   .scan_serial_out_oe_b(scan_serial_out_oe_b), .chain_active(chain_active),
   .id_parallel(id_parallel));

//--- tb/scan_data_regs_test.sv
`timescale 1ns/1ps
module scan_data_regs_test;
   localparam logic [31:0] ID = {scan_pkg::ID_VER_DEFAULT, scan_pkg::ID_PART_DEFAULT,
                                 scan_pkg::ID_MFR_DEFAULT, 1'b1};
   logic                 ref_clk = 1'b0;
   logic                 rst_b = 1'b0;
   logic                 scan_clock, scan_serial_in, scan_serial_out, oe_b, act, s, oe, d, p;
   logic [2:0]           instruction;
   scan_pkg::tap_state_t tap_state;
   logic [31:0]          id_parallel, obs_v, sh;
   logic [31:0]          exp_q[$];
   logic [2:0]           byp_ops[3] = '{3'h7, 3'h3, 3'h4};
   logic [2:0]           off_ops[4] = '{3'h0, 3'h2, 3'h5, 3'h6};
   string                obs_n;
   int                   miscompares = 0;
   int                   n_compared = 0;
   event                 obs_e;
   always #25 ref_clk = ~ref_clk;
   scan_data_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .scan_clock(scan_clock),
      .scan_serial_in(scan_serial_in), .instruction(instruction), .tap_state(tap_state),
      .scan_serial_out(scan_serial_out), .scan_serial_out_oe_b(oe_b),
      .chain_active(act), .id_parallel(id_parallel));
   scan_host host (.ref_clk(ref_clk), .scan_serial_out(scan_serial_out),
      .scan_serial_out_oe_b(oe_b), .scan_clock(scan_clock),
      .scan_serial_in(scan_serial_in), .instruction(instruction), .tap_state(tap_state));
   task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic obs(input string n, input logic [31:0] got, input logic [31:0] exp);
      exp_q.push_back(exp);
      obs_n = n;
      obs_v = got;
      ->obs_e;
      #0;
   endtask
   always @(obs_e)
      check(obs_n, obs_v, exp_q.pop_front());
   task automatic conclude;
      if (miscompares == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // about 60 scan cycles of 400 ns expected; generous margin
   initial
   begin
      #300000;
      miscompares++;
      conclude();
   end
   initial
   begin
      void'($urandom(32'he490216f));
      repeat (6) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      foreach (off_ops[i])
      begin
         host.cyc(off_ops[i], 4'b0010, 1'b1, s, oe);
         obs("oe_b", 32'(oe), 32'h1);
         obs("chain_active", 32'(act), 32'h0);
      end
      foreach (byp_ops[i])
      begin
         host.cyc(byp_ops[i], 4'b0100, 1'b1, s, oe);
         p = 1'b0;
         for (int k = 0; k < 6; k++)
         begin
            d = 1'($urandom);
            host.cyc(byp_ops[i], 4'b0010, d, s, oe);
            obs("bypass_out", 32'(s), 32'(p));
            obs("oe_b", 32'(oe), 32'h0);
            p = d;
         end
         obs("chain_active", 32'(act), 32'h1);
      end
      host.cyc(3'h1, 4'b0100, 1'b0, s, oe);
      for (int k = 0; k < 32; k++)
      begin
         d = 1'($urandom);
         host.cyc(3'h1, 4'b0010, d, s, oe);
         obs("id_out", 32'(s), 32'(ID[k]));
         obs("oe_b", 32'(oe), 32'h0);
         sh[k] = d;
      end
      host.cyc(3'h1, 4'b0001, 1'b0, s, oe);
      obs("id_parallel", id_parallel, sh);
      obs("oe_b", 32'(oe_b), 32'h1);
      host.cyc(3'h0, 4'b1000, 1'b0, s, oe);
      obs("id_parallel", id_parallel, ID);
      obs("chain_active", 32'(act), 32'h1);
      conclude();
   end
endmodule

//--- tb/scan_host.sv
`timescale 1ns/1ps
module scan_host (
   input  wire logic            ref_clk,
   input  wire logic            scan_serial_out,
   input  wire logic            scan_serial_out_oe_b,
   output logic                 scan_clock,
   output logic                 scan_serial_in,
   output logic [2:0]           instruction,
   output scan_pkg::tap_state_t tap_state
);
   initial
   begin
      scan_clock = 1'b0;
      scan_serial_in = 1'b0;
      instruction = 3'h1;
      tap_state = 4'b1000;
   end
   // state moves with the rise and holds past the fall, so both detected edges see it
   task automatic cyc(input logic [2:0] ins, input logic [3:0] st, input logic din,
                      output logic sout, output logic oe_b);
      instruction = ins;
      tap_state = st;
      scan_serial_in = din;
      scan_clock = 1'b1;
      repeat (4) @(posedge ref_clk);
      // released pin reads inverted so an undriven bit cannot pass
      #1 sout = scan_serial_out_oe_b ? ~scan_serial_out : scan_serial_out;
      oe_b = scan_serial_out_oe_b;
      scan_clock = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
endmodule
